// ---- rtl/dasout_pkg.sv ----
package dasout_pkg;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int LINK_CLOCK_HZ   = 24576000;
  localparam int FULL_RATE_HZ    = 48000;
  localparam int HALF_RATE_HZ    = 24000;
  localparam int CELLS_PER_FRAME = 128;
  localparam int FULL_CELL_DIV   =
    LINK_CLOCK_HZ / (FULL_RATE_HZ * CELLS_PER_FRAME);
  localparam int HALF_CELL_DIV   =
    LINK_CLOCK_HZ / (HALF_RATE_HZ * CELLS_PER_FRAME);
  localparam int FULL_FRAME_CYC  = FULL_CELL_DIV * CELLS_PER_FRAME;
  localparam int HALF_FRAME_CYC  = HALF_CELL_DIV * CELLS_PER_FRAME;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          SAMPLE_BITS  = 16;
  localparam int          WORD_BITS    = 2 * SAMPLE_BITS;
  localparam int          FIFO_DEPTH   = 16;
  localparam logic [6:0]  CELL_FIRST   = 7'h00;
  localparam logic [6:0]  CELL_LAST    = 7'h7F;
  localparam logic [7:0]  BLOCK_LAST   = 8'hBF;
  localparam logic [1:0]  BCLK_FALL    = 2'h0;
  localparam logic [4:0]  SLOT_FIRST   = 5'h00;
  localparam logic [4:0]  SLOT_AUX     = 5'h04;
  localparam logic [4:0]  SLOT_AUDIO   = 5'h0C;
  localparam logic [4:0]  SLOT_VALID   = 5'h1C;
  localparam logic [4:0]  SLOT_USER    = 5'h1D;
  localparam logic [4:0]  SLOT_STATUS  = 5'h1E;
  localparam logic [4:0]  SLOT_PARITY  = 5'h1F;

  // Preambles as transition patterns, first cell in the top bit.
  localparam logic [7:0]  PRE_BLOCK    = 8'h9C;
  localparam logic [7:0]  PRE_LEFT     = 8'h93;
  localparam logic [7:0]  PRE_RIGHT    = 8'h96;

  localparam logic        USER_BIT     = 1'b0;
  localparam logic        STATUS_BIT   = 1'b0;

endpackage : dasout_pkg

// ---- rtl/dasout_top.sv ----
`timescale 1ns/1ns
// How it works
// [RULE1] Serial audio port always drives bit clock, word select and data.
// [RULE2] Word select low during the left word, high during the right.
// [RULE3] Word MSB appears one bit clock after the word select edge.
// [RULE4] Word select runs at 48 kHz, or 24 kHz at half rate.
// [RULE5] Words are 16 bits; bit clock 1.536 MHz or 768 kHz.
// [RULE6] One frame per sample period: two 32-slot subframes, left, right.
// [RULE7] Every subframe slot after the preamble is bi-phase mark coded into two cells.
// [RULE8] Subframes open with a violating preamble that marks left or right.
// [RULE9] Last four slots carry validity, user, status, parity.
// [RULE10] Frames of 128 cells are sent at the sampling rate.
// [RULE11] Parity makes slots after the preamble hold an even count of ones.
// [RULE12] Left subframe first; both ports carry the same sample pair.

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module dasout_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so DEPTH must be a power of two.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_valid = (count_ff != '0);
  assign o_out_data  = mem[rd_ptr_ff];
  assign nxt_count   = count_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      count_ff   <= '0;
      o_in_ready <= 1'b0;
    end else begin
      wr_ptr_ff  <= wr_ptr_ff + AW'(push);
      rd_ptr_ff  <= rd_ptr_ff + AW'(pop);
      count_ff   <= nxt_count;
      o_in_ready <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

endmodule : dasout_fifo

// ------------------------------------------------------------------
// Audio output stage
// ------------------------------------------------------------------
module dasout_top #(
  parameter int FIFO_DEPTH = dasout_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Sample stream, left and right of one period together
  input  wire logic        i_sample_valid,
  output logic             o_sample_ready,
  input  wire logic [15:0] i_sample_left,
  input  wire logic [15:0] i_sample_right,
  // Rate select pin, high for the half sampling rate
  input  wire logic        i_half_rate,
  // Link clock and link outputs
  input  wire logic        i_audio_clock,
  output logic             o_audio_bit_clock,
  output logic             o_audio_word_select,
  output logic             o_audio_serial_data,
  output logic             o_digital_audio_frame
);
  localparam int WB = dasout_pkg::WORD_BITS;

  // Word layout: {valid, left, right}.
  logic          fifo_valid;
  logic [WB-1:0] fifo_data;
  logic          take;
  logic          req_s1_ff;
  logic          req_s2_ff;
  logic          req_seen_ff;
  logic          ack_tog_ff;
  logic [WB:0]   held_ff;

  logic          lrst_s1_ff;
  logic          lrst_n_ff;
  logic          half_s1_ff;
  logic          half_s2_ff;
  logic          ack_s1_ff;
  logic          ack_s2_ff;
  logic          ack_seen_ff;
  logic          req_tog_ff;
  logic [WB:0]   next_word_ff;
  logic [WB:0]   frame_word_ff;
  logic [3:0]    div_ff;
  logic [6:0]    cell_ff;
  logic [7:0]    block_ff;
  logic          par_ff;
  logic          tick;
  logic [4:0]    slot;
  logic [4:0]    i2s_slot;
  logic [15:0]   sample;
  logic [7:0]    pre;
  logic          bit_val;
  logic          toggle;
  logic          i2s_bit;

  // ----------------------------------------------------------------
  // System side: buffer and word hand-off
  // ----------------------------------------------------------------
  dasout_fifo #(
    .WIDTH (WB),
    .DEPTH (FIFO_DEPTH)
  ) u_dasout_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (o_sample_ready),
    .i_in_data   ({i_sample_left, i_sample_right}),
    .o_out_valid (fifo_valid),
    .i_out_ready (take),
    .o_out_data  (fifo_data)
  );

  assign take = (req_s2_ff != req_seen_ff);

  // One word per frame request; an empty FIFO answers with an invalid
  // silent word so the link never stalls.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      req_s1_ff   <= 1'b0;
      req_s2_ff   <= 1'b0;
      req_seen_ff <= 1'b0;
      ack_tog_ff  <= 1'b0;
      held_ff     <= '0;
    end else begin
      req_s1_ff   <= req_tog_ff;
      req_s2_ff   <= req_s1_ff;
      req_seen_ff <= req_s2_ff;
      if (take) begin
        held_ff    <= fifo_valid ? {1'b1, fifo_data} : '0;
        ack_tog_ff <= ~ack_tog_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link side: synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_audio_clock) begin
    lrst_s1_ff <= i_nrst;
    lrst_n_ff  <= lrst_s1_ff;
    half_s1_ff <= i_half_rate;
    half_s2_ff <= half_s1_ff;
    ack_s1_ff  <= ack_tog_ff;
    ack_s2_ff  <= ack_s1_ff;
  end

  // held_ff is stable for a whole frame after its toggle, so it may be
  // sampled directly once the acknowledge edge has been synchronised.
  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      ack_seen_ff  <= 1'b0;
      next_word_ff <= '0;
    end else if (ack_s2_ff != ack_seen_ff) begin
      ack_seen_ff  <= ack_s2_ff;
      next_word_ff <= held_ff;
    end
  end

  // ----------------------------------------------------------------
  // Cell timing
  // ----------------------------------------------------------------
  assign tick = (div_ff == '0);

  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= half_s2_ff ? 4'(dasout_pkg::HALF_CELL_DIV - 1)
                           : 4'(dasout_pkg::FULL_CELL_DIV - 1); // RULE4
    end else begin
      div_ff <= div_ff - 4'h1;
    end
  end

  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      cell_ff       <= dasout_pkg::CELL_FIRST;
      block_ff      <= '0;
      req_tog_ff    <= 1'b0;
      frame_word_ff <= '0;
    end else if (tick) begin
      cell_ff <= cell_ff + 7'h01; // RULE10
      if (cell_ff == dasout_pkg::CELL_LAST) begin
        block_ff <= (block_ff == dasout_pkg::BLOCK_LAST) ? '0
                                                          : block_ff + 8'h01;
      end
      // One pair feeds both ports for the same period.
      if (cell_ff == dasout_pkg::CELL_FIRST) begin
        frame_word_ff <= next_word_ff; // RULE12
        req_tog_ff    <= ~req_tog_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial audio port
  // ----------------------------------------------------------------
  assign i2s_slot = cell_ff[6:2];
  // Slot 0 still carries the last bit of the previous right word.
  assign i2s_bit  = (i2s_slot == dasout_pkg::SLOT_FIRST)
                  ? frame_word_ff[0]
                  : frame_word_ff[5'(5'h00 - i2s_slot)]; // RULE3

  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      o_audio_bit_clock   <= 1'b0;
      o_audio_word_select <= 1'b0;
      o_audio_serial_data <= 1'b0;
    end else if (tick) begin
      o_audio_bit_clock <= cell_ff[1]; // RULE1 RULE5
      if (cell_ff[1:0] == dasout_pkg::BCLK_FALL) begin
        o_audio_word_select <= cell_ff[6]; // RULE2
        o_audio_serial_data <= i2s_bit; // RULE3
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital audio frame output
  // ----------------------------------------------------------------
  assign slot   = cell_ff[5:1];
  assign sample = cell_ff[6] ? frame_word_ff[15:0] : frame_word_ff[31:16];
  assign pre    = cell_ff[6] ? dasout_pkg::PRE_RIGHT
                : (block_ff == '0) ? dasout_pkg::PRE_BLOCK
                : dasout_pkg::PRE_LEFT; // RULE8

  // The 16-bit sample sits in the top of the 24-bit audio field.
  always_comb begin
    bit_val = 1'b0;
    if (slot >= dasout_pkg::SLOT_AUDIO && slot < dasout_pkg::SLOT_VALID) begin
      bit_val = sample[4'(slot - dasout_pkg::SLOT_AUDIO)];
    end else if (slot == dasout_pkg::SLOT_VALID) begin
      bit_val = ~frame_word_ff[WB]; // RULE9
    end else if (slot == dasout_pkg::SLOT_USER) begin
      bit_val = dasout_pkg::USER_BIT; // RULE9
    end else if (slot == dasout_pkg::SLOT_STATUS) begin
      bit_val = dasout_pkg::STATUS_BIT; // RULE9
    end else if (slot == dasout_pkg::SLOT_PARITY) begin
      bit_val = par_ff; // RULE11
    end
  end

  // After the preamble, the first cell of a slot always flips; the second flips for a one.
  assign toggle = (slot < dasout_pkg::SLOT_AUX)
                ? pre[3'(~{slot[1:0], cell_ff[0]})]
                : (cell_ff[0] ? bit_val : 1'b1); // RULE7

  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      o_digital_audio_frame <= 1'b0;
      par_ff                <= 1'b0;
    end else if (tick) begin
      o_digital_audio_frame <= o_digital_audio_frame ^ toggle; // RULE6
      if (slot < dasout_pkg::SLOT_AUX) begin
        par_ff <= 1'b0;
      end else if (cell_ff[0] && slot != dasout_pkg::SLOT_PARITY) begin
        par_ff <= par_ff ^ bit_val; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] ws_cnt_ff;
  logic        ws_seen_ff;
  logic        ws_prev_ff;

  always_ff @(posedge i_audio_clock) begin
    if (!lrst_n_ff) begin
      ws_cnt_ff  <= '0;
      ws_seen_ff <= 1'b0;
      ws_prev_ff <= 1'b0;
    end else begin
      ws_prev_ff <= o_audio_word_select;
      if (o_audio_word_select && !ws_prev_ff) begin
        ws_cnt_ff  <= '0;
        ws_seen_ff <= 1'b1;
      end else begin
        ws_cnt_ff <= ws_cnt_ff + 11'h001;
      end
    end
  end

  // Every check below lives in the link domain.
  default clocking link_cb @(posedge i_audio_clock);
  endclocking
  default disable iff (!lrst_n_ff);

  sequence cell_at(logic [6:0] n);
    tick && cell_ff == n;
  endsequence

  ws_left_a: assert property ( // RULE2
    tick && !cell_ff[6] && cell_ff[1:0] == 2'h0 |=> !o_audio_word_select)
    else $error("word select not low for left word");
  ws_right_a: assert property ( // RULE2
    tick && cell_ff[6] && cell_ff[1:0] == 2'h0 |=> o_audio_word_select)
    else $error("word select not high for right word");
  msb_delay_a: assert property ( // RULE3
    cell_at(7'h04) |=> o_audio_serial_data == frame_word_ff[31])
    else $error("left MSB not one bit after word select");
  ws_period_a: assert property ( // RULE4
    o_audio_word_select && !ws_prev_ff && ws_seen_ff && !half_s2_ff
    |-> ws_cnt_ff == 11'(dasout_pkg::FULL_FRAME_CYC - 1))
    else $error("word select period wrong");
  bit_clock_a: assert property ( // RULE5
    tick && cell_ff[1:0] == 2'h2 |=> o_audio_bit_clock ##1 o_audio_bit_clock)
    else $error("bit clock not high in its second half");
  frame_wrap_a: assert property ( // RULE10
    cell_at(dasout_pkg::CELL_LAST) |=> cell_ff == dasout_pkg::CELL_FIRST)
    else $error("frame not 128 cells");
  biphase_a: assert property ( // RULE7
    tick && !cell_ff[0] && slot >= dasout_pkg::SLOT_AUX
    |=> $changed(o_digital_audio_frame))
    else $error("missing slot boundary transition");
  preamble_a: assert property ( // RULE8
    tick && cell_ff[5:0] == 6'h02 |=> $stable(o_digital_audio_frame))
    else $error("preamble violation missing");
  parity_a: assert property ( // RULE11
    cell_at(7'h3F) |=> $changed(o_digital_audio_frame)
      == (^frame_word_ff[31:16] ^ ~frame_word_ff[WB]))
    else $error("left parity not even");

endmodule : dasout_top

// ---- test/dasout_sink.sv ----
`timescale 1ns/1ns
// ------
// Receiver model for both audio links
// ------
module dasout_sink (
  // Link lines
  input  wire logic        i_audio_clock,
  input  wire logic        i_bit_clock,
  input  wire logic        i_word_select,
  input  wire logic        i_serial_data,
  input  wire logic        i_frame,
  input  wire logic [3:0]  i_cell_len,
  // Decoded pairs and counts
  output logic      [31:0] o_i2s_pair,
  output int               o_i2s_cnt,
  output logic      [31:0] o_sp_pair,
  output logic             o_sp_vbit,
  output int               o_err_cnt
);
  logic [15:0] sr;
  logic [15:0] left;
  logic [27:0] slot;
  logic [7:0]  hist;
  logic        ws_q;
  logic        lvl_q;
  logic        mid_q;
  logic        t;
  logic        side;
  logic        vl;
  logic        got_left = 1'b0;
  int          bits = 0;
  int          ph = 0;
  int          pos = 56;
  int          cnt = 0;
  int          i2s_err = 0;
  int          sp_err = 0;

  assign o_i2s_cnt = cnt;
  assign o_err_cnt = i2s_err + sp_err;

  // ------
  // Serial port, sampled on the rising bit clock
  // ------
  always @(posedge i_bit_clock) begin
    sr = {sr[14:0], i_serial_data};
    if (i_word_select !== ws_q) begin
      // A word ends with the bit that shares the word select edge.
      if (bits != 15) i2s_err++;
      if (ws_q) o_i2s_pair[15:0] = sr;
      else o_i2s_pair[31:16] = sr;
      if (ws_q) cnt++;
      bits = 0;
    end else begin
      bits++;
    end
    ws_q = i_word_select;
  end

  // ------
  // Frame line, one sample in the middle of each cell
  // ------
  always @(posedge i_audio_clock) begin
    // Phase follows every edge, so no free-running cell reference is kept.
    ph = (i_frame !== lvl_q) ? 0 : (ph + 1) % int'(i_cell_len);
    lvl_q = i_frame;
    if (ph == int'(i_cell_len) / 2) begin
      t = i_frame ^ mid_q;
      mid_q = i_frame;
      hist = {hist[6:0], t};
      if (pos < 56) begin
        if (pos % 2 == 1) slot[pos / 2] = t;
        pos++;
        if (pos == 56) begin
          if (slot[7:0] != 8'h00 || slot[26:25] != 2'h0) sp_err++;
          if (^slot) sp_err++;
          if (!side && got_left) sp_err++;
          if (!side) left = slot[23:8];
          if (!side) vl = slot[24];
          if (side && got_left) o_sp_pair = {left, slot[23:8]};
          if (side && got_left) o_sp_vbit = vl | slot[24];
          got_left = !side;
        end
      end else if (hist == dasout_pkg::PRE_BLOCK ||
                   hist == dasout_pkg::PRE_LEFT) begin
        side = 1'b0;
        pos = 0;
      end else if (hist == dasout_pkg::PRE_RIGHT) begin
        side = 1'b1;
        pos = 0;
      end
    end
  end
endmodule : dasout_sink

// ---- test/dasout_top_tb.sv ----
`timescale 1ns/1ns
module dasout_top_tb;
  logic        i_clock = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_sample_valid = 1'b0;
  logic [15:0] i_sample_left = 16'h0000;
  logic [15:0] i_sample_right = 16'h0000;
  logic        i_half_rate = 1'b0;
  logic        i_audio_clock = 1'b0;
  logic        o_sample_ready;
  logic        o_audio_bit_clock;
  logic        o_audio_word_select;
  logic        o_audio_serial_data;
  logic        o_digital_audio_frame;
  logic [31:0] i2s_pair;
  logic [31:0] sp_pair;
  logic        sp_vbit;
  logic        bclk_q;
  logic        ws_q;
  int          i2s_cnt;
  int          sink_err;
  int          bclk_n = 0;
  int          bclk_per = 0;
  int          ws_n = 0;
  int          ws_per = 0;
  int          err_count = 0;
  int          samples_checked = 0;

  initial begin
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    #7;
    forever #15 i_audio_clock = ~i_audio_clock;
  end

  dasout_top u_dasout_top (
    .i_clock               (i_clock),
    .i_nrst                (i_nrst),
    .i_sample_valid        (i_sample_valid),
    .o_sample_ready        (o_sample_ready),
    .i_sample_left         (i_sample_left),
    .i_sample_right        (i_sample_right),
    .i_half_rate           (i_half_rate),
    .i_audio_clock         (i_audio_clock),
    .o_audio_bit_clock     (o_audio_bit_clock),
    .o_audio_word_select   (o_audio_word_select),
    .o_audio_serial_data   (o_audio_serial_data),
    .o_digital_audio_frame (o_digital_audio_frame)
  );
  dasout_sink u_dasout_sink (
    .i_audio_clock (i_audio_clock),
    .i_bit_clock   (o_audio_bit_clock),
    .i_word_select (o_audio_word_select),
    .i_serial_data (o_audio_serial_data),
    .i_frame       (o_digital_audio_frame),
    .i_cell_len    (i_half_rate ? 4'h8 : 4'h4),
    .o_i2s_pair    (i2s_pair),
    .o_i2s_cnt     (i2s_cnt),
    .o_sp_pair     (sp_pair),
    .o_sp_vbit     (sp_vbit),
    .o_err_cnt     (sink_err)
  );

  // Periods in link cycles, between rising edges.
  always @(posedge i_audio_clock) begin
    bclk_n++;
    ws_n++;
    if (o_audio_bit_clock && !bclk_q) begin
      bclk_per = bclk_n;
      bclk_n = 0;
    end
    if (o_audio_word_select && !ws_q) begin
      ws_per = ws_n;
      ws_n = 0;
    end
    bclk_q = o_audio_bit_clock;
    ws_q = o_audio_word_select;
  end

  task check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task wait_frames(input int n);
    int c;
    repeat (n) begin
      c = i2s_cnt;
      for (int k = 0; k < 5000 && i2s_cnt == c; k++) @(negedge i_clock);
      check("frame seen", 32'(i2s_cnt != c), 32'h1);
    end
  endtask : wait_frames

  task do_reset(input logic half);
    @(negedge i_clock);
    i_nrst = 1'b0;
    i_half_rate = half;
    repeat (16) @(negedge i_clock);
    check("reset levels", 32'({o_sample_ready, o_audio_bit_clock,
      o_audio_word_select, o_audio_serial_data, o_digital_audio_frame}),
      32'h0);
    i_nrst = 1'b1;
    @(negedge i_clock);
    check("ready", 32'(o_sample_ready), 32'h1);
  endtask : do_reset

  task check_timing(input logic half);
    check("bit clock", bclk_per, half ? 32'h20 : 32'h10);
    check("word select", ws_per, half ? 32'h400 : 32'h200);
  endtask : check_timing

  task check_silence;
    check("i2s silence", i2s_pair, 32'h0);
    check("frame silence", sp_pair, 32'h0);
    check("invalid flag", 32'(sp_vbit), 32'h1);
  endtask : check_silence

  task test_idle;
    int e;
    wait_frames(3);
    e = sink_err;
    check_timing(1'b0);
    check_silence();
    wait_frames(2);
    check("sink", 32'(sink_err - e), 32'h0);
  endtask : test_idle

  task test_fill;
    logic [31:0] q[$];
    int          acc;
    int          e;
    acc = 0;
    e = sink_err;
    while (o_sample_ready === 1'b1 && acc < 20) begin
      i_sample_valid = 1'b1;
      i_sample_left = {1'b1, 7'(acc), 8'h01};
      i_sample_right = {1'b0, ~7'(acc), 8'hFE};
      q.push_back({i_sample_left, i_sample_right});
      acc++;
      @(negedge i_clock);
    end
    check("accepted", 32'(acc == 16 || acc == 17), 32'h1);
    // A beat offered while full stays up until the link drains a word.
    i_sample_left = 16'hDEAD;
    q.push_back({i_sample_left, i_sample_right});
    acc++;
    for (int k = 0; k < 4000 && o_sample_ready !== 1'b1; k++) begin
      @(negedge i_clock);
    end
    check("ready again", 32'(o_sample_ready), 32'h1);
    @(negedge i_clock);
    i_sample_valid = 1'b0;
    for (int k = 0; k < 4 && sp_vbit !== 1'b0; k++) wait_frames(1);
    repeat (acc) begin
      check("i2s pair", i2s_pair, q[0]);
      check("frame pair", sp_pair, q[0]);
      check("valid flag", 32'(sp_vbit), 32'h0);
      void'(q.pop_front());
      wait_frames(1);
    end
    check_silence();
    check("sink", 32'(sink_err - e), 32'h0);
  endtask : test_fill

  task test_rate;
    int e;
    do_reset(1'b1);
    wait_frames(3);
    e = sink_err;
    check_timing(1'b1);
    i_sample_valid = 1'b1;
    i_sample_left = 16'h8000;
    i_sample_right = 16'h0001;
    @(negedge i_clock);
    i_sample_valid = 1'b0;
    for (int k = 0; k < 4 && sp_vbit !== 1'b0; k++) wait_frames(1);
    check("half frame", sp_pair, 32'h80000001);
    check("half i2s", i2s_pair, 32'h80000001);
    check("sink", 32'(sink_err - e), 32'h0);
    do_reset(1'b0);
    wait_frames(3);
    check_timing(1'b0);
    check_silence();
  endtask : test_rate

  initial begin
    do_reset(1'b0);
    test_idle();
    test_fill();
    test_rate();
    end_sim();
  end

  // The full run needs about 0.6 ms; a hang is cut off well after that.
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end
endmodule : dasout_top_tb
